// ==== hw/core_interrupt_status.sv ====
// Upper core interrupt status word with AXI4-Lite register access
module core_interrupt_status
  import irq_status_pkg::*;
#(
  parameter int NUM_CH       = 16,
  parameter int NUM_EP       = 16,
  parameter int EARLY_CYCLES = EARLY_SUSPEND_CYCLES,
  parameter int SUSP_CYCLES  = SUSPEND_CYCLES
) (
  input  wire logic              aclk,                   // Clock
  input  wire logic              aresetn,                // Sync reset
  input  wire logic [7:0]        awaddr,                 // Write address
  input  wire logic              awvalid,                // Address valid
  output logic                   awready,                // Address taken
  input  wire logic [31:0]       wdata,                  // Write data
  input  wire logic [3:0]        wstrb,                  // Byte enables
  input  wire logic              wvalid,                 // Data valid
  output logic                   wready,                 // Data taken
  output logic [1:0]             bresp,                  // Write response
  output logic                   bvalid,                 // Response valid
  input  wire logic              bready,                 // Response taken
  input  wire logic [7:0]        araddr,                 // Read address
  input  wire logic              arvalid,                // Address valid
  output logic                   arready,                // Address taken
  output logic [31:0]            rdata,                  // Read data
  output logic [1:0]             rresp,                  // Read response
  output logic                   rvalid,                 // Read valid
  input  wire logic              rready,                 // Read taken
  input  wire ev_t               ev,                     // Event pulses
  input  wire lvl_t              lvl,                    // Status levels
  input  wire logic [NUM_CH-1:0] channel_interrupt,      // Per channel
  input  wire logic [NUM_EP-1:0] out_endpoint_interrupt, // Per OUT ep
  input  wire logic [NUM_EP-1:0] in_endpoint_interrupt,  // Per IN ep
  input  wire logic              soft_reset,             // Core soft reset
  output logic                   suspended,              // Suspend state
  output logic                   iso_packet_drop,        // Drop the packet
  output logic                   in_handshake_nak,       // Answer NAK
  output logic                   in_handshake_stall,     // Answer STALL
  output logic                   current_role            // 1 host, 0 device
);

  state_t s_reg;
  state_t s_next;

  // Expands byte enables into a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction

  // Marks a mapped register offset
  function automatic logic mapped(input logic [7:0] addr);
    return (addr == STATUS_OFFSET) || (addr == CONTROL_OFFSET);
  endfunction

  logic        do_write;
  logic        wr_status;
  logic        wr_control;
  logic        do_read;
  logic [31:0] wmask;
  logic [31:0] clr;
  logic [31:0] set;
  logic [31:0] ro;
  logic        host;
  logic        out_nak_eff;
  logic        in_nak_eff;
  ctl_t        ctl_wr;

  // Register file access decode
  always_comb begin
    do_write   = s_reg.aw_got && s_reg.w_got && !s_reg.bvalid;
    wmask      = lane_mask(s_reg.w_strb);
    wr_status  = do_write && (s_reg.aw_addr == STATUS_OFFSET);
    wr_control = do_write && (s_reg.aw_addr == CONTROL_OFFSET);
    do_read    = arvalid && !s_reg.rvalid;
    ctl_wr     = ctl_t'((s_reg.w_data[CTL_WIDTH-1:0] & wmask[CTL_WIDTH-1:0])
               | (s_reg.ctl & ~wmask[CTL_WIDTH-1:0]));
    clr        = wr_status ? (s_reg.w_data & wmask & STICKY_MASK)
                           : 32'h0000_0000;
    host       = s_reg.stat[BIT_ROLE];
    out_nak_eff = s_reg.stat[BIT_OUTNAK];
    in_nak_eff  = s_reg.stat[BIT_INNAK];
  end

  // Event sources of the sticky flags
  always_comb begin
    set = 32'h0000_0000;
    set[BIT_CONN_ID] = ev.connector_identity_change;
    set[BIT_LPM]     = s_reg.ctl.link_power_capable
                     && (host ? (ev.lpm_host_retry_done
                                 || ev.lpm_host_reply_ok)
                              : ev.lpm_dev_accept);
    set[BIT_FETCH]   = ev.fetch_stall && s_reg.ctl.dma_mode;
    set[BIT_INCOMP]  = host ? ev.periodic_incomplete
                     : (ev.periodic_frame_interval
                        && lvl.iso_out_pending);
    set[BIT_ISO_IN]  = ev.periodic_frame_interval && lvl.iso_in_pending
                     && !s_reg.ctl.scatter_gather;
    set[BIT_MISMAT]  = ev.endpoint_mismatch
                     && s_reg.ctl.shared_fifo;
    set[BIT_RESTORE] = ev.restore_complete
                     && s_reg.ctl.hibernation_en;
    set[BIT_END_OF_PERIODIC_FRAME]    = ev.periodic_frame_interval;
    set[BIT_ISODROP] = ev.iso_out_no_room;
    set[BIT_ENUM]    = ev.speed_enumeration_done;
    set[BIT_BUSRST]  = ev.bus_reset_seen;
    set[BIT_SUSP]    = (s_reg.line != LINE_SUSP) && lvl.line_idle
                     && (32'(s_reg.idle_cnt) >= 32'(SUSP_CYCLES - 1));
    set[BIT_ESUSP]   = (s_reg.line == LINE_ACTIVE) && lvl.line_idle
                     && (32'(s_reg.idle_cnt) >= 32'(EARLY_CYCLES - 1));
    set[BIT_SERIAL]  = ev.side_serial_done
                     && s_reg.ctl.side_serial_present;
    set[BIT_CARKIT]  = s_reg.ctl.carkit_present
                     && ((ev.carkit_event
                          && (lvl.carkit_uart_mode
                              || lvl.carkit_audio_mode))
                         || (ev.serial_carkit_event
                             && lvl.carkit_audio_mode));
  end

  // Read-only summary and state bits
  always_comb begin
    ro = 32'h0000_0000;
    ro[BIT_PTX_EMP] = lvl.preq_space
                    && (s_reg.ctl.periodic_empty_level
                        ? lvl.ptx_full_empty
                        : lvl.ptx_half_empty);
    ro[BIT_HCH] = host && (|channel_interrupt);
    ro[BIT_OEP] = !host && (|out_endpoint_interrupt);
    ro[BIT_IEP] = !host && (|in_endpoint_interrupt);
    ro[BIT_OUTNAK] = !(wr_control && ctl_wr.clear_global_out_nak)
                   && (out_nak_eff
                       || (s_reg.out_nak_req && lvl.out_path_idle));
    ro[BIT_INNAK]  = !(wr_control && ctl_wr.clear_global_in_nak)
                   && (in_nak_eff || s_reg.in_nak_req);
    ro[BIT_ROLE] = (ev.restore_complete && s_reg.ctl.hibernation_en)
                 ? s_reg.ctl.restore_target_mode
                 : lvl.core_role;
  end

  // Next state of the whole block
  always_comb begin
    s_next = s_reg;
    // Write address and data are taken in either order
    if (awvalid && !s_reg.aw_got) begin
      s_next.aw_got  = 1'b1;
      s_next.aw_addr = awaddr;
    end
    if (wvalid && !s_reg.w_got) begin
      s_next.w_got  = 1'b1;
      s_next.w_data = wdata;
      s_next.w_strb = wstrb;
    end
    if (do_write) begin
      s_next.aw_got = 1'b0;
      s_next.w_got  = 1'b0;
      s_next.bvalid = 1'b1;
      s_next.bresp  = mapped(s_reg.aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_reg.bvalid && bready) begin
      s_next.bvalid = 1'b0;
    end
    // Read answers one cycle after the address is taken
    if (do_read) begin
      s_next.rvalid = 1'b1;
      s_next.rresp  = mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
      if (araddr == STATUS_OFFSET) begin
        s_next.rdata = s_reg.stat;
      end else if (araddr == CONTROL_OFFSET) begin
        s_next.rdata = {{(32-CTL_WIDTH){1'b0}},
                        s_reg.ctl & ~CONTROL_CMD_MASK};
      end else begin
        s_next.rdata = 32'h0000_0000;
      end
    end else if (s_reg.rvalid && rready) begin
      s_next.rvalid = 1'b0;
    end
    // Control word, command bits act once and never store
    if (wr_control) begin
      s_next.ctl = ctl_t'(ctl_wr & ~CONTROL_CMD_MASK);
    end
    // Global NAK requests wait until they take effect
    if (wr_control && ctl_wr.set_global_out_nak) begin
      s_next.out_nak_req = 1'b1;
    end
    if (wr_control && ctl_wr.clear_global_out_nak) begin
      s_next.out_nak_req = 1'b0;
    end
    if (wr_control && ctl_wr.set_global_in_nak) begin
      s_next.in_nak_req = 1'b1;
    end
    if (wr_control && ctl_wr.clear_global_in_nak) begin
      s_next.in_nak_req = 1'b0;
    end
    // Sticky flags: a new event wins over a same-cycle clear
    s_next.stat = ((s_reg.stat & STICKY_MASK & ~clr) | set)
                | ro;
    // Line idle timing and suspend state
    if (!lvl.line_idle) begin
      s_next.idle_cnt = 20'h0_0000;
      s_next.line     = LINE_ACTIVE;
    end else begin
      if (32'(s_reg.idle_cnt) < 32'(SUSP_CYCLES)) begin
        s_next.idle_cnt = s_reg.idle_cnt + 20'h0_0001;
      end
      if (set[BIT_ESUSP]) begin
        s_next.line = LINE_EARLY;
      end
      if (set[BIT_SUSP]) begin
        s_next.line = LINE_SUSP;
      end
    end
    if (set[BIT_RESTORE]) begin
      s_next.line     = LINE_ACTIVE;
      s_next.idle_cnt = 20'h0_0000;
    end
    s_next.iso_drop    = ev.iso_out_no_room;
    s_next.in_hs_stall = lvl.ep_stall;
    s_next.in_hs_nak   = ro[BIT_INNAK] && !lvl.ep_stall;
    // Core soft reset clears the flags and the NAK requests
    if (soft_reset) begin
      s_next.stat        = (STATUS_RESET & ~STICKY_MASK) | ro;
      s_next.out_nak_req = 1'b0;
      s_next.in_nak_req  = 1'b0;
      s_next.stat[BIT_OUTNAK] = 1'b0;
      s_next.stat[BIT_INNAK]  = 1'b0;
      s_next.line        = LINE_ACTIVE;
      s_next.idle_cnt    = 20'h0_0000;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_reg         <= '0;
      s_reg.stat    <= STATUS_RESET;
      s_reg.ctl     <= ctl_t'(CONTROL_RESET);
      s_reg.line    <= LINE_ACTIVE;
      s_reg.bresp   <= RESP_OKAY;
      s_reg.rresp   <= RESP_OKAY;
    end else begin
      s_reg <= s_next;
    end
  end

  // Outputs straight from the state register
  assign awready            = !s_reg.aw_got;
  assign wready             = !s_reg.w_got;
  assign bvalid             = s_reg.bvalid;
  assign bresp              = s_reg.bresp;
  assign arready            = !s_reg.rvalid;
  assign rvalid             = s_reg.rvalid;
  assign rdata              = s_reg.rdata;
  assign rresp              = s_reg.rresp;
  assign suspended          = (s_reg.line == LINE_SUSP);
  assign iso_packet_drop    = s_reg.iso_drop;
  assign in_handshake_nak   = s_reg.in_hs_nak;
  assign in_handshake_stall = s_reg.in_hs_stall;
  assign current_role       = s_reg.stat[BIT_ROLE];

endmodule

// ==== hw/irq_status_pkg.sv ====
// Constants, carrier types and state of the core interrupt status block
package irq_status_pkg;
  localparam logic [7:0]  CONTROL_OFFSET = 8'h00;
  localparam logic [7:0]  STATUS_OFFSET  = 8'h14;
  localparam logic [31:0] STATUS_RESET   = 32'h0000_0000;
  localparam logic [31:0] STICKY_MASK    = 32'h1873_FF00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam int BIT_CONN_ID = 28;
  localparam int BIT_LPM     = 27;
  localparam int BIT_PTX_EMP = 26;
  localparam int BIT_HCH     = 25;
  localparam int BIT_FETCH   = 22;
  localparam int BIT_INCOMP  = 21;
  localparam int BIT_ISO_IN  = 20;
  localparam int BIT_OEP     = 19;
  localparam int BIT_IEP     = 18;
  localparam int BIT_MISMAT  = 17;
  localparam int BIT_RESTORE = 16;
  localparam int BIT_END_OF_PERIODIC_FRAME    = 15;
  localparam int BIT_ISODROP = 14;
  localparam int BIT_ENUM    = 13;
  localparam int BIT_BUSRST  = 12;
  localparam int BIT_SUSP    = 11;
  localparam int BIT_ESUSP   = 10;
  localparam int BIT_SERIAL  = 9;
  localparam int BIT_CARKIT  = 8;
  localparam int BIT_OUTNAK  = 7;
  localparam int BIT_INNAK   = 6;
  localparam int BIT_ROLE    = 0;
  localparam int CTL_WIDTH   = 13;
  localparam logic [CTL_WIDTH-1:0] CONTROL_RESET = 13'h0000;
  localparam logic [CTL_WIDTH-1:0] CONTROL_CMD_MASK = 13'h1E00;
  localparam int EARLY_SUSPEND_MS = 3;
  localparam int SUSPEND_MS       = 4;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int EARLY_SUSPEND_CYCLES =
    EARLY_SUSPEND_MS * 1000000 / CLK_PERIOD_NS;
  localparam int SUSPEND_CYCLES = SUSPEND_MS * 1000000 / CLK_PERIOD_NS;

  // Software control word, command bits 12..9 read back as zero
  typedef struct packed {
    logic clear_global_in_nak;   // 12
    logic set_global_in_nak;     // 11
    logic clear_global_out_nak;  // 10
    logic set_global_out_nak;    // 9
    logic carkit_present;        // 8
    logic side_serial_present;   // 7
    logic restore_target_mode;   // 6
    logic hibernation_en;        // 5
    logic shared_fifo;           // 4
    logic scatter_gather;        // 3
    logic dma_mode;              // 2
    logic periodic_empty_level;  // 1: fully empty, 0: half empty
    logic link_power_capable;    // 0
  } ctl_t;

  // One-cycle event pulses from the rest of the core
  typedef struct packed {
    logic connector_identity_change;
    logic lpm_dev_accept;
    logic lpm_host_retry_done;
    logic lpm_host_reply_ok;
    logic fetch_stall;
    logic periodic_incomplete;
    logic endpoint_mismatch;
    logic restore_complete;
    logic periodic_frame_interval;
    logic iso_out_no_room;
    logic speed_enumeration_done;
    logic bus_reset_seen;
    logic side_serial_done;
    logic carkit_event;
    logic serial_carkit_event;
  } ev_t;

  // Level status from the rest of the core
  typedef struct packed {
    logic       ptx_half_empty;
    logic       ptx_full_empty;
    logic       preq_space;
    logic       iso_out_pending;
    logic       iso_in_pending;
    logic       line_idle;
    logic       out_path_idle;
    logic       ep_stall;
    logic       core_role;
    logic       carkit_uart_mode;
    logic       carkit_audio_mode;
  } lvl_t;

  typedef enum logic [1:0] {
    LINE_ACTIVE = 2'b00,
    LINE_EARLY  = 2'b01,
    LINE_SUSP   = 2'b10
  } line_state_t;

  typedef struct packed {
    logic        aw_got;
    logic [7:0]  aw_addr;
    logic        w_got;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [31:0] stat;
    ctl_t        ctl;
    logic        out_nak_req;
    logic        in_nak_req;
    line_state_t line;
    logic [19:0] idle_cnt;
    logic        iso_drop;
    logic        in_hs_nak;
    logic        in_hs_stall;
  } state_t;
endpackage

// ==== verification/core_interrupt_status_checker.sv ====
// Concurrent checks on the core interrupt status block ports
module core_interrupt_status_checker
  import irq_status_pkg::*;
#(
  parameter int EARLY_CYCLES = 8,
  parameter int SUSP_CYCLES  = 12
) (
  input wire logic        aclk,               // Clock
  input wire logic        aresetn,            // Sync reset
  input wire logic        awvalid,            // Address valid
  input wire logic        awready,            // Address taken
  input wire logic        wvalid,             // Data valid
  input wire logic        wready,             // Data taken
  input wire logic [1:0]  bresp,              // Write response
  input wire logic        bvalid,             // Response valid
  input wire logic        bready,             // Response taken
  input wire logic        arvalid,            // Address valid
  input wire logic        arready,            // Address taken
  input wire logic [31:0] rdata,              // Read data
  input wire logic        rvalid,             // Read valid
  input wire logic        rready,             // Read taken
  input wire ev_t         ev,                 // Event pulses
  input wire lvl_t        lvl,                // Status levels
  input wire logic        suspended,          // Suspend state
  input wire logic        iso_packet_drop,    // Drop the packet
  input wire logic        in_handshake_nak,   // Answer NAK
  input wire logic        in_handshake_stall, // Answer STALL
  input wire logic        current_role        // Role
);
  int idle_run;

  // Counts consecutive idle line samples
  always_ff @(posedge aclk) begin
    if (!aresetn || !lvl.line_idle) begin
      idle_run <= 0;
    end else if (idle_run < SUSP_CYCLES + 4) begin
      idle_run <= idle_run + 1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data taken together
  sequence both_taken;
    awvalid && awready && wvalid && wready;
  endsequence

  write_answer_a: assert property (both_taken |-> ##2 bvalid)
    else $error("write response late");
  resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  read_answer_a: assert property (arvalid && arready |=> rvalid && !arready)
    else $error("read answer late");
  read_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  drop_pulse_a: assert property (ev.iso_out_no_room |=> iso_packet_drop)
    else $error("packet drop missing");
  drop_cause_a: assert property (iso_packet_drop |->
    $past(ev.iso_out_no_room)) else $error("packet drop without cause");
  stall_follow_a: assert property ($past(aresetn) |->
    in_handshake_stall == $past(lvl.ep_stall)) else $error("stall lag wrong");
  nak_yield_a: assert property (in_handshake_nak |->
    !in_handshake_stall) else $error("NAK beside STALL");
  role_follow_a: assert property ($past(aresetn)
    && !$past(ev.restore_complete) |-> current_role == $past(lvl.core_role))
    else $error("role wrong");
  idle_wake_a: assert property (!lvl.line_idle |=> !suspended)
    else $error("suspend kept on activity");
  suspend_idle_a: assert property (suspended |->
    idle_run >= SUSP_CYCLES) else $error("suspend too early");
endmodule

bind core_interrupt_status core_interrupt_status_checker #(
  .EARLY_CYCLES(EARLY_CYCLES), .SUSP_CYCLES(SUSP_CYCLES)
) i_checker (
  .aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
  .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
  .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .ev(ev), .lvl(lvl),
  .suspended(suspended), .iso_packet_drop(iso_packet_drop),
  .in_handshake_nak(in_handshake_nak),
  .in_handshake_stall(in_handshake_stall), .current_role(current_role)
);

// ==== verification/core_interrupt_status_test.sv ====
// Self-checking bench for the core interrupt status block
module core_interrupt_status_test
  import irq_status_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic aclk = 1'b0, aresetn = 1'b0, soft_reset = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, suspended;
  logic iso_packet_drop, in_handshake_nak, in_handshake_stall, current_role;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, e;
  logic [1:0]  bresp, rresp, r;
  logic [3:0]  strb = 4'hF;
  logic [15:0] ch = 16'h0, oep = 16'h0, iep = 16'h0;
  ev_t         ev = '0;
  lvl_t        lvl = '0;
  logic [12:0] ctl = 13'h01B5;
  logic [14:0] hostk = 15'h1A00;
  logic [14:0] gated = 15'h3D87;
  int sbit [15] = '{8, 8, 9, 12, 13, 14, 15, 16, 17, 21, 22, 27, 27, 27, 28};
  int errors = 0;
  int checks = 0;

  always #5 aclk = ~aclk;

  core_interrupt_status #(.EARLY_CYCLES(8), .SUSP_CYCLES(12)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(strb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .ev(ev), .lvl(lvl),
    .channel_interrupt(ch), .out_endpoint_interrupt(oep),
    .in_endpoint_interrupt(iep), .soft_reset(soft_reset),
    .suspended(suspended), .iso_packet_drop(iso_packet_drop),
    .in_handshake_nak(in_handshake_nak),
    .in_handshake_stall(in_handshake_stall), .current_role(current_role)
  );

  task automatic chk(input string s, input logic [31:0] x,
                     input logic [31:0] v);
    checks++;
    if (v !== x) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", s, x, v);
    end
  endtask

  // Write cycle: offer both channels, release each as taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [1:0] x);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
    end while (!bvalid && n < 50);
    chk("bvalid", 32'h1, {31'h0, bvalid});
    bready <= 1'b0;
    chk("bresp", {30'h0, x}, {30'h0, bresp});
  endtask

  // Read cycle: hold request until taken, data at rvalid edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] q);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
    end while (!rvalid && n < 50);
    chk("rvalid", 32'h1, {31'h0, rvalid});
    rready <= 1'b0;
    v = rdata;
    q = rresp;
  endtask

  task automatic rs(input logic [31:0] x);
    logic [31:0] v;
    logic [1:0]  q;
    rd(STATUS_OFFSET, v, q);
    chk("status", x, v);
  endtask

  task automatic pulse(input int k);
    ev[k] <= 1'b1;
    @(posedge aclk);
    ev[k] <= 1'b0;
  endtask

  task automatic done(input string s);
    $display("Test %s finished", s);
  endtask

  task automatic stop_test;
    $display("Checks %0d mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Watchdog cuts a hang short
  initial begin
    #200000;
    errors++;
    stop_test;
  end

  // Main sequence
  initial begin
    lvl.carkit_uart_mode = 1'b1;
    lvl.carkit_audio_mode = 1'b1;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rs(32'h0);
    rd(CONTROL_OFFSET, d, r);
    chk("control", 32'h0, d);
    for (int k = 0; k < 15; k++) begin
      if (gated[k]) begin
        lvl.core_role <= hostk[k];
        pulse(k);
        rs({31'h0, hostk[k]});
      end
    end
    done("gating");
    wr(CONTROL_OFFSET, {19'h0, ctl}, RESP_OKAY);
    for (int k = 0; k < 15; k++) begin
      e = 32'h1 << sbit[k];
      lvl.core_role <= hostk[k];
      @(posedge aclk);
      pulse(k);
      rs(e | hostk[k]);
      wr(STATUS_OFFSET, ~e, RESP_OKAY);
      rs(e | hostk[k]);
      wr(STATUS_OFFSET, e, RESP_OKAY);
      rs({31'h0, hostk[k]});
    end
    done("sticky");
    lvl.core_role <= 1'b0;
    lvl.iso_out_pending <= 1'b1;
    lvl.iso_in_pending <= 1'b1;
    pulse(6);
    rs(32'h0030_8000);
    wr(STATUS_OFFSET, 32'h0030_8000, RESP_OKAY);
    wr(CONTROL_OFFSET, {19'h0, ctl | 13'h0008}, RESP_OKAY);
    pulse(6);
    rs(32'h0020_8000);
    wr(STATUS_OFFSET, 32'h0020_8000, RESP_OKAY);
    done("iso");
    lvl.core_role <= 1'b1;
    ch <= 16'h0008;
    oep <= 16'h8000;
    iep <= 16'h0001;
    @(posedge aclk);
    rs(32'h0200_0001);
    lvl.core_role <= 1'b0;
    wr(STATUS_OFFSET, 32'h020C_0000, RESP_OKAY);
    rs(32'h000C_0000);
    ch <= 16'h0;
    oep <= 16'h0;
    iep <= 16'h0;
    rs(32'h0);
    lvl.ptx_half_empty <= 1'b1;
    lvl.preq_space <= 1'b1;
    rs(32'h0400_0000);
    wr(CONTROL_OFFSET, {19'h0, ctl | 13'h0002}, RESP_OKAY);
    rs(32'h0);
    lvl.ptx_full_empty <= 1'b1;
    rs(32'h0400_0000);
    lvl.preq_space <= 1'b0;
    rs(32'h0);
    done("summary");
    lvl.out_path_idle <= 1'b1;
    wr(CONTROL_OFFSET, {19'h0, ctl | 13'h0200}, RESP_OKAY);
    rs(32'h80);
    rd(CONTROL_OFFSET, d, r);
    chk("control", {19'h0, ctl}, d);
    wr(CONTROL_OFFSET, {19'h0, ctl | 13'h0400}, RESP_OKAY);
    rs(32'h0);
    wr(CONTROL_OFFSET, {19'h0, ctl | 13'h0800}, RESP_OKAY);
    rs(32'h40);
    chk("nak", 32'h1, {31'h0, in_handshake_nak});
    lvl.ep_stall <= 1'b1;
    repeat (3) @(posedge aclk);
    chk("nak", 32'h0, {31'h0, in_handshake_nak});
    chk("stall", 32'h1, {31'h0, in_handshake_stall});
    lvl.ep_stall <= 1'b0;
    wr(CONTROL_OFFSET, {19'h0, ctl | 13'h1000}, RESP_OKAY);
    rs(32'h0);
    done("nak");
    lvl.line_idle <= 1'b1;
    repeat (5) @(posedge aclk);
    lvl.line_idle <= 1'b0;
    rs(32'h0);
    lvl.line_idle <= 1'b1;
    repeat (16) @(posedge aclk);
    rs(32'h0C00);
    chk("suspended", 32'h1, {31'h0, suspended});
    pulse(7);
    @(posedge aclk);
    chk("suspended", 32'h0, {31'h0, suspended});
    lvl.line_idle <= 1'b0;
    wr(STATUS_OFFSET, 32'h0001_0C00, RESP_OKAY);
    rs(32'h0);
    done("suspend");
    ev.bus_reset_seen <= 1'b1;
    wr(STATUS_OFFSET, 32'h1000, RESP_OKAY);
    rs(32'h1000);
    ev.bus_reset_seen <= 1'b0;
    wr(STATUS_OFFSET, 32'h1000, RESP_OKAY);
    rs(32'h0);
    pulse(3);
    strb <= 4'hD;
    wr(STATUS_OFFSET, 32'h1000, RESP_OKAY);
    rs(32'h1000);
    strb <= 4'hF;
    soft_reset <= 1'b1;
    @(posedge aclk);
    soft_reset <= 1'b0;
    rs(32'h0);
    wr(8'h08, 32'hFFFF_FFFF, RESP_SLVERR);
    rd(8'h08, d, r);
    chk("rdata", 32'h0, d);
    chk("rresp", {30'h0, RESP_SLVERR}, {30'h0, r});
    done("clear");
    stop_test;
  end
endmodule
